// ---- wemc_pkg.sv ----
// Constants and types shared by the wake event, mask and edge controller
`default_nettype none
package wemc_pkg;
   // Register addresses on the controller's memory-mapped space
   localparam logic [15:0] ADDR_SERIAL_IRQ_GEN = 16'h7f52;
   localparam logic [15:0] ADDR_SRC_LGPIO = 16'h7f55;
   localparam logic [15:0] ADDR_MASK_LGPIO = 16'h7f56;
   localparam logic [15:0] ADDR_ESEL_G0_LOW = 16'h7f57;
   localparam logic [15:0] ADDR_ESEL_G0_HIGH = 16'h7f58;
   localparam logic [15:0] ADDR_SRC_EDGE_G0 = 16'h7f59;
   localparam logic [15:0] ADDR_MASK_EDGE_G0 = 16'h7f5a;
   localparam logic [15:0] ADDR_ESEL_G1_LOW = 16'h7f5c;
   localparam logic [15:0] ADDR_ESEL_G1_HIGH = 16'h7f5d;
   localparam logic [15:0] ADDR_SRC_EDGE_G1 = 16'h7f5e;
   localparam logic [15:0] ADDR_MASK_EDGE_G1 = 16'h7f5f;
   localparam logic [15:0] ADDR_ESEL_G2_LOW = 16'h7f61;
   localparam logic [15:0] ADDR_ESEL_G2_HIGH = 16'h7f62;
   localparam logic [15:0] ADDR_SRC_EDGE_G2 = 16'h7f63;
   localparam logic [15:0] ADDR_SRC_FAN_FLOPPY = 16'h7f64;
   localparam logic [15:0] ADDR_MASK_FAN_FLOPPY = 16'h7f65;
   localparam logic [15:0] ADDR_MASK_EDGE_G2 = 16'h7f66;
   localparam logic [15:0] ADDR_POWER_GOOD_LOST = 16'h7f84;
   localparam logic [15:0] ADDR_HIB_COUNTDOWN = 16'h7ff3;

   // Reset values
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [19:0] RST_PRESCALE = 20'h00000;

   // Field layouts
   localparam int SIRQ_SEL_LSB = 4;
   localparam int SIRQ_MAP_EN_BIT = 3;
   localparam int SIRQ_ASSERT_BIT = 2;
   localparam logic [7:0] SIRQ_WR_MASK = 8'hfc;
   localparam logic [7:0] FAN_FLOPPY_WR_MASK = 8'h07;
   localparam int PG_LOST_BIT = 0;

   // Wake groups: three edge groups, fan and floppy, host gpio
   localparam int GRP_EDGE0 = 0;
   localparam int GRP_EDGE1 = 1;
   localparam int GRP_EDGE2 = 2;
   localparam int GRP_FAN_FLOPPY = 3;
   localparam int GRP_LGPIO = 4;
   localparam int NUM_GRP = 5;
   localparam int NUM_EDGE_SRC = 24;
   localparam int NUM_ESEL = 6;

   // Edge select field encoding
   typedef enum logic [1:0] {
      EDGE_FALL = 2'b00,
      EDGE_RISE = 2'b01,
      EDGE_EITHER = 2'b10,
      EDGE_RSVD = 2'b11
   } wemc_edge_type;

   // Hibernation unit, counted in slow clock rising edges
   localparam int HIB_UNIT_S = 30;
   localparam int SLOW_CLK_HZ = 32768;
   localparam int HIB_TICK_EDGES = HIB_UNIT_S * SLOW_CLK_HZ;
endpackage
`default_nettype wire

// ---- wemc_wake_ctrl.sv ----
// Wake source masks, edge selects, hibernation timer and serial irq map
//
// Overview of operation
// - Mask bit one blocks its wake interrupt
// - Masked sources still latch; masks reset clear
// - Status bits stick until written with one
// - Fan and floppy mask: three low bits only
// - Infrared edge input has no digital filter
// - Hibernation counter: 8 bits, 30 s units
// - At zero counter holds and raises wake
// - Counter paced by the 32 kHz clock
// - Non-zero write loads and starts the count
// - Edge groups drive external inputs two-four
// - Edge field: fall, rise, either, reserved
// - Four 2-bit fields per select register
// - Reconfiguring edge select raises no interrupt by itself
// - Power-good loss sets flag, never while good
// - Power-good-lost flag drives power-fail interrupt
// - Flag clears by writing one to bit 0
// - Firmware can raise a host serial irq
// - Serial irq set and cleared only by firmware
// - Select 7:4, enable 3, assert 2, reserved 1:0
// - Disabled or select zero gives no irq
// - Line asserted only with enable and assert
`timescale 1ns/1ps
`default_nettype none
module wemc_wake_ctrl #(
   parameter int unsigned HIB_TICK_EDGES = wemc_pkg::HIB_TICK_EDGES
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [15:0] i_addr,
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [7:0] i_wdata,
   input wire logic [23:0] i_edge_src,
   input wire logic [2:0] i_fan_floppy_wake,
   input wire logic [7:0] i_host_gpio_wake,
   input wire logic i_main_power_good_in,
   input wire logic i_slow_clk,
   output logic [7:0] o_rdata,
   output logic o_ext_irq_input_two,
   output logic o_ext_irq_input_three,
   output logic o_ext_irq_input_four,
   output logic o_other_wake_irq,
   output logic o_hib_wake,
   output logic o_power_fail_irq,
   output logic [15:0] o_host_irq
);

   localparam logic [19:0] PRE_LAST = 20'(HIB_TICK_EDGES - 1);

   logic [7:0] mask_q [wemc_pkg::NUM_GRP];
   logic [7:0] mask_d [wemc_pkg::NUM_GRP];
   logic [7:0] src_q [wemc_pkg::NUM_GRP];
   logic [7:0] src_d [wemc_pkg::NUM_GRP];
   logic [7:0] esel_q [wemc_pkg::NUM_ESEL];
   logic [7:0] esel_d [wemc_pkg::NUM_ESEL];
   logic [7:0] ev [wemc_pkg::NUM_GRP];
   logic [7:0] sirq_q;
   logic [7:0] sirq_d;
   logic pg_q;
   logic pg_d;
   logic pg_prev_q;
   logic [23:0] edge_prev_q;
   logic [23:0] edge_ev;
   logic [7:0] hib_q;
   logic [7:0] hib_d;
   logic [19:0] pre_q;
   logic [19:0] pre_d;
   logic slow_prev_q;
   logic slow_rise;
   logic hib_wr;
   logic wake_d;
   logic [7:0] rdata_d;
   logic irq2_d;
   logic irq3_d;
   logic irq4_d;
   logic other_d;
   logic [15:0] host_irq_d;

   // Edge detection per selectable source; no glitch filter is applied,
   // so a noisy infrared line needs an external filter
   genvar gi;
   generate
      for (gi = 0; gi < wemc_pkg::NUM_EDGE_SRC; gi++) begin : g_edge
         logic [1:0] sel;
         logic rise;
         logic fall;
         assign sel = esel_q[gi / 4][2 * (gi % 4) +: 2];
         assign rise = i_edge_src[gi] & ~edge_prev_q[gi];
         assign fall = ~i_edge_src[gi] & edge_prev_q[gi];
         // Reserved code detects nothing
         always_comb begin
            case (sel)
               wemc_pkg::EDGE_FALL: edge_ev[gi] = fall;
               wemc_pkg::EDGE_RISE: edge_ev[gi] = rise;
               wemc_pkg::EDGE_EITHER: edge_ev[gi] = rise | fall;
               default: edge_ev[gi] = 1'b0;
            endcase
         end
      end
   endgenerate

   // Event vectors per wake group; fan, floppy and gpio are level events
   always_comb begin
      ev[wemc_pkg::GRP_EDGE0] = edge_ev[7:0];
      ev[wemc_pkg::GRP_EDGE1] = edge_ev[15:8];
      ev[wemc_pkg::GRP_EDGE2] = edge_ev[23:16];
      ev[wemc_pkg::GRP_FAN_FLOPPY] = {5'h00, i_fan_floppy_wake};
      ev[wemc_pkg::GRP_LGPIO] = i_host_gpio_wake;
   end

   // Register writes, sticky status and the power-good flag
   always_comb begin
      mask_d = mask_q;
      esel_d = esel_q;
      sirq_d = sirq_q;
      for (int g = 0; g < wemc_pkg::NUM_GRP; g++) begin
         src_d[g] = src_q[g];
      end
      pg_d = pg_q;
      if (i_wr_en) begin
         case (i_addr)
            wemc_pkg::ADDR_MASK_EDGE_G0:
               mask_d[wemc_pkg::GRP_EDGE0] = i_wdata;
            wemc_pkg::ADDR_MASK_EDGE_G1:
               mask_d[wemc_pkg::GRP_EDGE1] = i_wdata;
            wemc_pkg::ADDR_MASK_EDGE_G2:
               mask_d[wemc_pkg::GRP_EDGE2] = i_wdata;
            wemc_pkg::ADDR_MASK_FAN_FLOPPY:
               mask_d[wemc_pkg::GRP_FAN_FLOPPY] =
                  i_wdata & wemc_pkg::FAN_FLOPPY_WR_MASK;
            wemc_pkg::ADDR_MASK_LGPIO:
               mask_d[wemc_pkg::GRP_LGPIO] = i_wdata;
            wemc_pkg::ADDR_SRC_EDGE_G0:
               src_d[wemc_pkg::GRP_EDGE0] = src_q[0] & ~i_wdata;
            wemc_pkg::ADDR_SRC_EDGE_G1:
               src_d[wemc_pkg::GRP_EDGE1] = src_q[1] & ~i_wdata;
            wemc_pkg::ADDR_SRC_EDGE_G2:
               src_d[wemc_pkg::GRP_EDGE2] = src_q[2] & ~i_wdata;
            wemc_pkg::ADDR_SRC_FAN_FLOPPY:
               src_d[wemc_pkg::GRP_FAN_FLOPPY] = src_q[3] & ~i_wdata;
            wemc_pkg::ADDR_SRC_LGPIO:
               src_d[wemc_pkg::GRP_LGPIO] = src_q[4] & ~i_wdata;
            // New select takes effect next cycle; the change itself
            // produces no status, since events come only from input edges
            wemc_pkg::ADDR_ESEL_G0_LOW: esel_d[0] = i_wdata;
            wemc_pkg::ADDR_ESEL_G0_HIGH: esel_d[1] = i_wdata;
            wemc_pkg::ADDR_ESEL_G1_LOW: esel_d[2] = i_wdata;
            wemc_pkg::ADDR_ESEL_G1_HIGH: esel_d[3] = i_wdata;
            wemc_pkg::ADDR_ESEL_G2_LOW: esel_d[4] = i_wdata;
            wemc_pkg::ADDR_ESEL_G2_HIGH: esel_d[5] = i_wdata;
            // Only firmware touches this register
            wemc_pkg::ADDR_SERIAL_IRQ_GEN:
               sirq_d = i_wdata & wemc_pkg::SIRQ_WR_MASK;
            wemc_pkg::ADDR_POWER_GOOD_LOST:
               if (i_wdata[wemc_pkg::PG_LOST_BIT]) begin
                  pg_d = 1'b0;
               end
            default: ;
         endcase
      end
      // Events latch regardless of mask; set wins over clear
      for (int g = 0; g < wemc_pkg::NUM_GRP; g++) begin
         src_d[g] = src_d[g] | ev[g];
      end
      // Flag only sets on a falling power-good
      if (pg_prev_q && !i_main_power_good_in) begin
         pg_d = 1'b1;
      end
   end

   // Register state; pg_prev resets high so a dead plane at reset flags
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         for (int g = 0; g < wemc_pkg::NUM_GRP; g++) begin
            mask_q[g] <= wemc_pkg::RST_REG;
            src_q[g] <= wemc_pkg::RST_REG;
         end
         for (int e = 0; e < wemc_pkg::NUM_ESEL; e++) begin
            esel_q[e] <= wemc_pkg::RST_REG;
         end
         sirq_q <= wemc_pkg::RST_REG;
         pg_q <= 1'b0;
         pg_prev_q <= 1'b1;
         edge_prev_q <= 24'h000000;
      end else begin
         mask_q <= mask_d;
         src_q <= src_d;
         esel_q <= esel_d;
         sirq_q <= sirq_d;
         pg_q <= pg_d;
         pg_prev_q <= i_main_power_good_in;
         edge_prev_q <= i_edge_src;
      end
   end

   // Hibernation countdown, stepped by a prescaler of slow clock edges
   always_comb begin
      slow_rise = i_slow_clk & ~slow_prev_q;
      hib_wr = i_wr_en && (i_addr == wemc_pkg::ADDR_HIB_COUNTDOWN);
      hib_d = hib_q;
      pre_d = pre_q;
      wake_d = 1'b0;
      if (hib_wr) begin
         // A zero write stops the timer without a wake
         hib_d = i_wdata;
         pre_d = wemc_pkg::RST_PRESCALE;
      end else if (hib_q != 8'h00 && slow_rise) begin
         if (pre_q == PRE_LAST) begin
            pre_d = wemc_pkg::RST_PRESCALE;
            hib_d = hib_q - 8'h01;
            wake_d = (hib_q == 8'h01);
         end else begin
            pre_d = pre_q + 20'h00001;
         end
      end
   end

   // Hibernation state
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         hib_q <= wemc_pkg::RST_REG;
         pre_q <= wemc_pkg::RST_PRESCALE;
         slow_prev_q <= 1'b0;
         o_hib_wake <= 1'b0;
      end else begin
         hib_q <= hib_d;
         pre_q <= pre_d;
         slow_prev_q <= i_slow_clk;
         o_hib_wake <= wake_d;
      end
   end

   // Interrupt outputs computed from next state so the flops mirror
   // the registers with no extra lag; read data from current state
   always_comb begin
      irq2_d = |(src_d[0] & ~mask_d[0]);
      irq3_d = |(src_d[1] & ~mask_d[1]);
      irq4_d = |(src_d[2] & ~mask_d[2]);
      other_d = |(src_d[3] & ~mask_d[3]) | |(src_d[4] & ~mask_d[4]);
      host_irq_d = 16'h0000;
      // Select zero maps to bit 0, which is never driven
      if (sirq_d[wemc_pkg::SIRQ_MAP_EN_BIT] &&
          sirq_d[wemc_pkg::SIRQ_ASSERT_BIT]) begin
         host_irq_d[sirq_d[7:4]] = 1'b1;
      end
      host_irq_d[0] = 1'b0;
      rdata_d = o_rdata;
      if (i_rd_en) begin
         case (i_addr)
            wemc_pkg::ADDR_MASK_EDGE_G0: rdata_d = mask_q[0];
            wemc_pkg::ADDR_MASK_EDGE_G1: rdata_d = mask_q[1];
            wemc_pkg::ADDR_MASK_EDGE_G2: rdata_d = mask_q[2];
            wemc_pkg::ADDR_MASK_FAN_FLOPPY: rdata_d = mask_q[3];
            wemc_pkg::ADDR_MASK_LGPIO: rdata_d = mask_q[4];
            wemc_pkg::ADDR_SRC_EDGE_G0: rdata_d = src_q[0];
            wemc_pkg::ADDR_SRC_EDGE_G1: rdata_d = src_q[1];
            wemc_pkg::ADDR_SRC_EDGE_G2: rdata_d = src_q[2];
            wemc_pkg::ADDR_SRC_FAN_FLOPPY: rdata_d = src_q[3];
            wemc_pkg::ADDR_SRC_LGPIO: rdata_d = src_q[4];
            wemc_pkg::ADDR_ESEL_G0_LOW: rdata_d = esel_q[0];
            wemc_pkg::ADDR_ESEL_G0_HIGH: rdata_d = esel_q[1];
            wemc_pkg::ADDR_ESEL_G1_LOW: rdata_d = esel_q[2];
            wemc_pkg::ADDR_ESEL_G1_HIGH: rdata_d = esel_q[3];
            wemc_pkg::ADDR_ESEL_G2_LOW: rdata_d = esel_q[4];
            wemc_pkg::ADDR_ESEL_G2_HIGH: rdata_d = esel_q[5];
            wemc_pkg::ADDR_SERIAL_IRQ_GEN: rdata_d = sirq_q;
            wemc_pkg::ADDR_POWER_GOOD_LOST: rdata_d = {7'h00, pg_q};
            wemc_pkg::ADDR_HIB_COUNTDOWN: rdata_d = hib_q;
            default: rdata_d = 8'h00;
         endcase
      end
   end

   // Output flops
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rdata <= wemc_pkg::RST_REG;
         o_ext_irq_input_two <= 1'b0;
         o_ext_irq_input_three <= 1'b0;
         o_ext_irq_input_four <= 1'b0;
         o_other_wake_irq <= 1'b0;
         o_power_fail_irq <= 1'b0;
         o_host_irq <= 16'h0000;
      end else begin
         o_rdata <= rdata_d;
         o_ext_irq_input_two <= irq2_d;
         o_ext_irq_input_three <= irq3_d;
         o_ext_irq_input_four <= irq4_d;
         o_other_wake_irq <= other_d;
         o_power_fail_irq <= pg_d;
         o_host_irq <= host_irq_d;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   a_mask_gates_irq: assert property (
      o_ext_irq_input_two == |(src_q[0] & ~mask_q[0]))
      else $error("group0 irq does not follow masked status");
   a_masked_latches: assert property (
      (i_host_gpio_wake[0] && mask_q[4][0]) |=> src_q[4][0])
      else $error("masked gpio event not latched");
   a_status_sticky: assert property (
      (src_q[1][0] && !(i_wr_en &&
         i_addr == wemc_pkg::ADDR_SRC_EDGE_G1 && i_wdata[0]))
      |=> src_q[1][0])
      else $error("status bit cleared without write");
   a_status_w1c: assert property (
      (i_wr_en && i_addr == wemc_pkg::ADDR_SRC_EDGE_G1 && i_wdata[0]
         && !edge_ev[8]) |=> !src_q[1][0])
      else $error("write one did not clear status");
   a_fan_mask_rsvd: assert property (
      mask_q[3][7:3] == 5'h00)
      else $error("reserved fan mask bits set");
   a_fall_detect: assert property (
      (esel_q[0][3:2] == 2'b00 && edge_prev_q[1] && !i_edge_src[1])
      |=> src_q[0][1] && (o_ext_irq_input_two || mask_q[0][1]))
      else $error("falling edge not detected");
   a_hib_hold_zero: assert property (
      (hib_q == 8'h00 && !hib_wr) |=> (hib_q == 8'h00 && !o_hib_wake))
      else $error("hibernation counter left zero");
   a_hib_wake_pulse: assert property (
      o_hib_wake |-> (hib_q == 8'h00 && $past(hib_q) == 8'h01))
      else $error("wake without expiry");
   a_hib_load: assert property (
      hib_wr |=> hib_q == $past(i_wdata))
      else $error("hibernation load failed");
   a_hib_step: assert property (
      !hib_wr |=> (hib_q == $past(hib_q) ||
         (hib_q == $past(hib_q) - 8'h01 && $past(pre_q) == PRE_LAST)))
      else $error("hibernation counter stepped wrongly");
   a_pg_no_set_good: assert property (
      $rose(pg_q) |-> !$past(i_main_power_good_in))
      else $error("flag set while power good");
   a_pg_drives_pfi: assert property (
      o_power_fail_irq == pg_q)
      else $error("power fail irq differs from flag");
   a_host_irq_gate: assert property (
      (sirq_q[3:2] != 2'b11 || sirq_q[7:4] == 4'h0) |-> o_host_irq == 16'h0)
      else $error("host irq without enable and assert");
   a_host_irq_map: assert property (
      (sirq_q[3:2] == 2'b11 && sirq_q[7:4] != 4'h0)
      |-> o_host_irq == (16'h0001 << sirq_q[7:4]))
      else $error("host irq mapped to wrong line");
endmodule
`default_nettype wire

// ---- wemc_far_model.sv ----
// Far-side model: standby slow clock source pacing the hibernation timer
`timescale 1ns/1ps
`default_nettype none
module wemc_far_model #(
   // Whole fast clock periods, so edges never meet the rising sample edge
   parameter int HALF_NS = 160
) (
   input wire logic i_run,
   output logic o_slow_clk
);
   // Runs only while enabled and parks low, so no stray ticks between tests
   initial o_slow_clk = 1'b0;
   always begin
      #(HALF_NS);
      o_slow_clk = i_run ? ~o_slow_clk : 1'b0;
   end
endmodule
`default_nettype wire

// ---- wemc_wake_ctrl_bench.sv ----
// Self-checking bench for the wake event, mask and edge controller
`timescale 1ns/1ps
`default_nettype none
module wemc_wake_ctrl_bench;
   // Short hibernation unit keeps the run brief
   localparam int TICK = 2;
   localparam logic [15:0] REGS [14] = '{16'h7f52, 16'h7f56, 16'h7f57,
      16'h7f58, 16'h7f5c, 16'h7f5d, 16'h7f5f, 16'h7f61, 16'h7f62,
      16'h7f65, 16'h7f66, 16'h7f84, 16'h7ff3, 16'h7f60};
   localparam logic [7:0] RBACK [14] = '{8'hfc, 8'hff, 8'hff, 8'hff,
      8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h07, 8'hff, 8'h00, 8'hff, 8'h00};
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, pg = 1'b1;
   logic run = 1'b0, slow, irq2, irq3, irq4, other, hib, pfail;
   logic [15:0] addr = 16'h0000, hirq;
   logic [7:0] wdata = 8'h00, rdata, gpw = 8'h00;
   logic [23:0] esrc = 24'h000000;
   logic [2:0] ffw = 3'h0;
   int err_count = 0, checks = 0, rise_cnt = 0;

   always #20 clk = ~clk;
   // Counts slow clock rises seen since the last timer load
   always @(posedge slow) rise_cnt++;

   wemc_wake_ctrl #(.HIB_TICK_EDGES(TICK)) dut (.i_clk(clk), .i_rst(rst),
      .i_addr(addr), .i_wr_en(wr), .i_rd_en(rd), .i_wdata(wdata),
      .i_edge_src(esrc), .i_fan_floppy_wake(ffw), .i_host_gpio_wake(gpw),
      .i_main_power_good_in(pg), .i_slow_clk(slow), .o_rdata(rdata),
      .o_ext_irq_input_two(irq2), .o_ext_irq_input_three(irq3),
      .o_ext_irq_input_four(irq4), .o_other_wake_irq(other),
      .o_hib_wake(hib), .o_power_fail_irq(pfail), .o_host_irq(hirq));
   wemc_far_model far (.i_run(run), .o_slow_clk(slow));

   task automatic summarize();
      if (err_count == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask

   // One-cycle strobes, driven on the falling edge
   task automatic wreg(logic [15:0] a, logic [7:0] d);
      @(negedge clk);
      wr = 1'b1;
      addr = a;
      wdata = d;
      @(negedge clk);
      wr = 1'b0;
   endtask

   task automatic rchk(string what, logic [15:0] a, logic [7:0] exp);
      @(negedge clk);
      rd = 1'b1;
      addr = a;
      @(negedge clk);
      rd = 1'b0;
      chk(what, {8'h00, exp}, {8'h00, rdata});
   endtask

   // Reset values, writable bits and an unmapped address
   task automatic t_regs();
      foreach (REGS[i]) rchk("reset value", REGS[i], 8'h00);
      foreach (REGS[i]) wreg(REGS[i], 8'hff);
      foreach (REGS[i]) rchk("read back", REGS[i], RBACK[i]);
      chk("host irq", 16'h8000, hirq);
      foreach (REGS[i]) wreg(REGS[i], 8'h00);
   endtask

   // Every select value with and without enable and assert
   task automatic t_sirq();
      for (int n = 0; n < 16; n++) begin
         wreg(16'h7f52, 8'(n << 4) | 8'h0c);
         chk("mapped line", 16'(1 << n) & 16'hfffe, hirq);
         wreg(16'h7f52, 8'(n << 4) | 8'h08);
         chk("enable only", 16'h0000, hirq);
         wreg(16'h7f52, 8'(n << 4) | 8'h04);
         chk("assert only", 16'h0000, hirq);
      end
      wreg(16'h7f52, 8'h5c);
      repeat (50) @(negedge clk);
      chk("held line", 16'h0020, hirq);
      wreg(16'h7f52, 8'h58);
      chk("cleared line", 16'h0000, hirq);
   endtask

   // Fall on a low field, rise and either on high fields, of every group
   task automatic t_edge();
      logic [15:0] sl [3] = '{16'h7f57, 16'h7f5c, 16'h7f61};
      logic [15:0] sh [3] = '{16'h7f58, 16'h7f5d, 16'h7f62};
      logic [15:0] st [3] = '{16'h7f59, 16'h7f5e, 16'h7f63};
      int s;
      logic [7:0] f;
      logic [7:0] m;
      logic [2:0] gb;
      for (int g = 0; g < 3; g++) begin
         gb = 3'(1 << g);
         for (int c = 0; c < 3; c++) begin
            s = c * 3 + 1;
            m = 8'(1 << s);
            // Other fields reserved, so only the source under test reacts
            f = ~(8'h03 << 2 * (s % 4)) | 8'(c << 2 * (s % 4));
            wreg(s < 4 ? sl[g] : sh[g], f);
            wreg(st[g], 8'hff);
            @(negedge clk);
            esrc[g * 8 + s] = 1'b1;
            repeat (2) @(negedge clk);
            chk("rise irq", c ? gb : 3'h0, {irq4, irq3, irq2});
            rchk("rise status", st[g], c ? m : 8'h00);
            wreg(st[g], 8'hff);
            esrc[g * 8 + s] = 1'b0;
            repeat (2) @(negedge clk);
            rchk("fall status", st[g], c == 1 ? 8'h00 : m);
            wreg(st[g], 8'(1 << s));
            rchk("cleared status", st[g], 8'h00);
            chk("cleared irq", 3'h0, {irq4, irq3, irq2});
         end
      end
   endtask

   // Masked sources latch but stay silent
   task automatic t_mask();
      wreg(16'h7f5f, 8'h01);
      wreg(16'h7f5c, 8'h01);
      esrc[8] = 1'b1;
      repeat (2) @(negedge clk);
      chk("masked irq", 16'h0000, {15'h0000, irq3});
      rchk("masked status", 16'h7f5e, 8'h01);
      wreg(16'h7f5f, 8'h00);
      @(negedge clk);
      chk("unmasked irq", 16'h0001, {15'h0000, irq3});
      esrc[8] = 1'b0;
      wreg(16'h7f5e, 8'h01);
      ffw = 3'h4;
      gpw = 8'h01;
      wreg(16'h7f56, 8'h01);
      repeat (2) @(negedge clk);
      chk("floppy irq", 16'h0001, {15'h0000, other});
      wreg(16'h7f65, 8'h04);
      @(negedge clk);
      chk("floppy masked", 16'h0000, {15'h0000, other});
      ffw = 3'h0;
      gpw = 8'h00;
      rchk("floppy status", 16'h7f64, 8'h04);
      rchk("gpio status", 16'h7f55, 8'h01);
      wreg(16'h7f64, 8'h04);
      wreg(16'h7f55, 8'h01);
      wreg(16'h7f65, 8'h00);
      wreg(16'h7f56, 8'h00);
   endtask

   // Loss of main power good, clear while still low, return
   task automatic t_power();
      chk("flag while good", 16'h0000, {15'h0000, pfail});
      pg = 1'b0;
      repeat (2) @(negedge clk);
      chk("power fail irq", 16'h0001, {15'h0000, pfail});
      rchk("flag read", 16'h7f84, 8'h01);
      wreg(16'h7f84, 8'h01);
      @(negedge clk);
      chk("flag cleared", 16'h0000, {15'h0000, pfail});
      pg = 1'b1;
      repeat (4) @(negedge clk);
      rchk("flag after return", 16'h7f84, 8'h00);
   endtask

   // Count of three units, then hold at zero
   task automatic t_hib();
      int pulses = 0;
      wreg(16'h7ff3, 8'h03);
      rise_cnt = 0;
      run = 1'b1;
      for (int n = 0; n < 2000 && hib !== 1'b1; n++) @(negedge clk);
      chk("hibernation wake", 16'h0001, {15'h0000, hib});
      if (hib !== 1'b1)
         summarize();
      chk("slow edges to wake", 16'(3 * TICK), 16'(rise_cnt));
      @(negedge clk);
      chk("wake pulse width", 16'h0000, {15'h0000, hib});
      repeat (60) begin
         @(negedge clk);
         pulses += int'(hib);
      end
      run = 1'b0;
      chk("no second wake", 16'h0000, 16'(pulses));
      rchk("counter held", 16'h7ff3, 8'h00);
   endtask

   initial begin
      repeat (3) @(negedge clk);
      rst = 1'b0;
      t_regs();
      t_sirq();
      t_edge();
      t_mask();
      t_power();
      t_hib();
      summarize();
   end
endmodule
`default_nettype wire
